// [logic/gsd_top.sv]
// register bank: auxiliary pins, data-ready, self-test and error flags
// Operation
// - direction bit 1 makes a line output, 0 input; bit0 line a, bit1 line b
// - output line level follows level bit; bit 9 line b, bit 8 line a
// - data-ready toggles selected line after each sample update that comes while no pulse runs, then restores it
// - misc bit 2 enables data-ready, bit 1 polarity, bit 0 line select
// - writing misc bit 10 starts internal self-test; result ready within 35 ms
// - self-test outcome shows in flag bit 5; host waits before reading
// - external stimulus held while bit 9 (negative) or bit 8 (positive) set
// - flag bit 9 for alarm 2, bit 8 for alarm 1, 1 means active
// - flag bits 5,4,3,2: self-test, overrange, comm failure, update failure
// - flag bit 1 supply high, bit 0 supply low, zero when normal
// - supply and overrange flags clear themselves when the condition goes
// - other flags stick until a flag read, which returns then clears them
// - line claims resolve misc first, alarm second, pin config last
// - a line configured as input reads its pin level in bit 0 or 1
`default_nettype none
module gsd_top #(
  parameter int unsigned ST_CYCLES   = gsd_pkg::GSD_ST_CYCLES,
  parameter int unsigned DRDY_CYCLES = gsd_pkg::GSD_DRDY_CYCLES
) (
  input  wire logic                    core_clk,
  input  wire logic                    nrst,
  input  wire logic                    ce,
  input  wire logic [7:0]              reg_addr,
  input  wire logic                    reg_wr,
  input  wire logic [15:0]             reg_wdata,
  input  wire logic                    reg_rd,
  output logic      [15:0]             reg_rdata,
  input  wire logic                    sample_update,
  input  wire gsd_pkg::gsd_cond_t      cond,
  input  wire gsd_pkg::gsd_alarm_pin_t alarm_pin,
  input  wire logic                    aux_line_a_in,
  output logic                         aux_line_a_out,
  output logic                         aux_line_a_oe,
  input  wire logic                    aux_line_b_in,
  output logic                         aux_line_b_out,
  output logic                         aux_line_b_oe,
  output logic                         st_pos,
  output logic                         st_neg,
  output logic                         selftest_run
);
  localparam int STW = $clog2(ST_CYCLES + 1);
  localparam int PW  = $clog2(DRDY_CYCLES + 1);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [15:0]           pin_q;
  logic [15:0]           pin_d;
  logic [15:0]           misc_q;
  logic [15:0]           misc_d;
  logic [15:0]           flags_q;
  logic [15:0]           flags_d;
  logic [15:0]           rdata_d;
  gsd_pkg::gsd_st_state_t st_q;
  gsd_pkg::gsd_st_state_t st_d;
  logic [STW-1:0]        st_cnt_q;
  logic [STW-1:0]        st_cnt_d;
  logic                  st_done;
  logic                  pulse_q;
  logic                  pulse_d;
  logic [PW-1:0]         pcnt_q;
  logic [PW-1:0]         pcnt_d;
  logic [1:0]            oe_d;
  logic [1:0]            out_d;
  logic [1:0]            oe_q;
  logic [1:0]            out_q;
  logic [1:0]            pin_sync;
  logic                  wr_pin;
  logic                  wr_misc;
  logic                  rd_flags;
  logic [15:0]           flag_set;

  // pins come from outside the clock domain
  gsd_sync #(.W(2)) u_pin_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .ce       (ce),
    .d        ({aux_line_b_in, aux_line_a_in}),
    .q        (pin_sync)
  );

  // ------------------------------------------------------------
  // register access decode
  // ------------------------------------------------------------
  assign wr_pin   = ce && reg_wr && (reg_addr == gsd_pkg::GSD_ADDR_PIN);
  assign wr_misc  = ce && reg_wr && (reg_addr == gsd_pkg::GSD_ADDR_MISC);
  assign rd_flags = ce && reg_rd && (reg_addr == gsd_pkg::GSD_ADDR_FLAGS);
  assign st_done  = (st_q == gsd_pkg::GSD_ST_RUN) && (st_cnt_q == STW'(ST_CYCLES - 1));

  // ------------------------------------------------------------
  // control registers and internal self-test sequencer
  // ------------------------------------------------------------
  // a write while the test runs keeps bit 10 set so the run is not cut short
  always_comb begin
    pin_d    = pin_q;
    misc_d   = misc_q;
    st_d     = st_q;
    st_cnt_d = st_cnt_q;
    if (wr_pin) begin
      pin_d = reg_wdata & gsd_pkg::GSD_MASK_PIN;
    end
    if (wr_misc) begin
      misc_d = reg_wdata & gsd_pkg::GSD_MASK_MISC;
      if (st_q == gsd_pkg::GSD_ST_RUN) begin
        misc_d[gsd_pkg::GSD_MISC_IST] = 1'b1;
      end
    end
    if (ce) begin
      unique case (st_q)
        gsd_pkg::GSD_ST_IDLE: begin
          if (wr_misc && reg_wdata[gsd_pkg::GSD_MISC_IST]) begin
            st_d     = gsd_pkg::GSD_ST_RUN;
            st_cnt_d = '0;
          end
        end
        gsd_pkg::GSD_ST_RUN: begin
          if (st_done) begin
            st_d                          = gsd_pkg::GSD_ST_IDLE;
            misc_d[gsd_pkg::GSD_MISC_IST] = 1'b0;
          end else begin
            st_cnt_d = st_cnt_q + STW'(1);
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pin_q    <= gsd_pkg::GSD_RST_PIN;
      misc_q   <= gsd_pkg::GSD_RST_MISC;
      st_q     <= gsd_pkg::GSD_ST_IDLE;
      st_cnt_q <= '0;
    end else begin
      pin_q    <= pin_d;
      misc_q   <= misc_d;
      st_q     <= st_d;
      st_cnt_q <= st_cnt_d;
    end
  end

  // ------------------------------------------------------------
  // error flags
  // ------------------------------------------------------------
  // a new event in the read cycle survives the clear: set wins
  always_comb begin
    flag_set                        = '0;
    flag_set[gsd_pkg::GSD_FLG_ALM2] = cond.alarm2;
    flag_set[gsd_pkg::GSD_FLG_ALM1] = cond.alarm1;
    flag_set[gsd_pkg::GSD_FLG_ST]   = st_done && cond.st_fail;
    flag_set[gsd_pkg::GSD_FLG_COMM] = cond.comm_fail;
    flag_set[gsd_pkg::GSD_FLG_UPD]  = cond.upd_fail;
    flags_d = flags_q;
    if (ce) begin
      flags_d = (rd_flags ? 16'h0000 : flags_q) | flag_set;
      flags_d[gsd_pkg::GSD_FLG_OVR]   = cond.overrange;
      flags_d[gsd_pkg::GSD_FLG_SUPHI] = cond.supply_hi;
      flags_d[gsd_pkg::GSD_FLG_SUPLO] = cond.supply_lo;
      flags_d = flags_d & gsd_pkg::GSD_MASK_FLAGS;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flags_q <= gsd_pkg::GSD_RST_FLAGS;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ------------------------------------------------------------
  // data-ready pulse timer
  // ------------------------------------------------------------
  // fixed width; duty stays in window only for sample periods near the fastest
  always_comb begin
    pulse_d = pulse_q;
    pcnt_d  = pcnt_q;
    if (ce) begin
      if (!misc_q[gsd_pkg::GSD_MISC_EN]) begin
        pulse_d = 1'b0;
        pcnt_d  = '0;
      end else if (pulse_q) begin
        if (pcnt_q == PW'(DRDY_CYCLES - 1)) begin
          pulse_d = 1'b0;
          pcnt_d  = '0;
        end else begin
          pcnt_d = pcnt_q + PW'(1);
        end
      end else if (sample_update) begin
        pulse_d = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pulse_q <= 1'b0;
      pcnt_q  <= '0;
    end else begin
      pulse_q <= pulse_d;
      pcnt_q  <= pcnt_d;
    end
  end

  // ------------------------------------------------------------
  // line drivers: misc beats alarm beats pin config
  // ------------------------------------------------------------
  always_comb begin
    oe_d  = oe_q;
    out_d = out_q;
    if (ce) begin
      for (int i = 0; i < 2; i++) begin
        if (misc_q[gsd_pkg::GSD_MISC_EN] && (misc_q[gsd_pkg::GSD_MISC_SEL] == (i == 1))) begin
          oe_d[i]  = 1'b1;
          out_d[i] = pulse_q ~^ misc_q[gsd_pkg::GSD_MISC_POL];
        end else if (alarm_pin.en[i]) begin
          oe_d[i]  = 1'b1;
          out_d[i] = alarm_pin.lvl[i];
        end else begin
          oe_d[i]  = pin_q[gsd_pkg::GSD_PIN_DIR_A + i];
          out_d[i] = pin_q[gsd_pkg::GSD_PIN_DIR_A + i] &&
                     pin_q[gsd_pkg::GSD_PIN_LVL_A + i];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // read data, stimulus and status outputs
  // ------------------------------------------------------------
  always_comb begin
    rdata_d = reg_rdata;
    if (ce && reg_rd) begin
      unique case (reg_addr)
        gsd_pkg::GSD_ADDR_PIN: begin
          rdata_d = pin_q;
          for (int i = 0; i < 2; i++) begin
            if (!pin_q[gsd_pkg::GSD_PIN_DIR_A + i]) begin
              rdata_d[gsd_pkg::GSD_PIN_DIR_A + i] = pin_sync[i];
            end
          end
        end
        gsd_pkg::GSD_ADDR_MISC:  rdata_d = misc_q;
        gsd_pkg::GSD_ADDR_FLAGS: rdata_d = flags_q;
        default:                 rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      oe_q         <= 2'h0;
      out_q        <= 2'h0;
      reg_rdata    <= 16'h0000;
      st_pos       <= 1'b0;
      st_neg       <= 1'b0;
      selftest_run <= 1'b0;
    end else begin
      oe_q      <= oe_d;
      out_q     <= out_d;
      reg_rdata <= rdata_d;
      if (ce) begin
        st_pos       <= misc_q[gsd_pkg::GSD_MISC_XPOS];
        st_neg       <= misc_q[gsd_pkg::GSD_MISC_XNEG];
        selftest_run <= (st_q == gsd_pkg::GSD_ST_RUN);
      end
    end
  end

  assign aux_line_a_oe  = oe_q[0];
  assign aux_line_a_out = out_q[0];
  assign aux_line_b_oe  = oe_q[1];
  assign aux_line_b_out = out_q[1];

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_st_go;
    ce && (st_q == gsd_pkg::GSD_ST_IDLE) && wr_misc && reg_wdata[gsd_pkg::GSD_MISC_IST];
  endsequence
  sequence s_st_fail_end;
    ce && st_done && cond.st_fail;
  endsequence
  sequence s_drdy_a;
    ce && misc_q[gsd_pkg::GSD_MISC_EN] && !misc_q[gsd_pkg::GSD_MISC_SEL];
  endsequence

  AST_OE_DIR: assert property (ce && !misc_q[gsd_pkg::GSD_MISC_EN] && !alarm_pin.en[0]
    |=> aux_line_a_oe == $past(pin_q[0]))
    else $error("line a enable does not follow direction bit");
  AST_OUT_LVL: assert property (ce && !misc_q[gsd_pkg::GSD_MISC_EN] && !alarm_pin.en[1]
    && pin_q[1] |=> aux_line_b_oe && (aux_line_b_out == $past(pin_q[9])))
    else $error("line b level does not follow level bit");
  AST_DRDY_WIDTH: assert property ($fell(pulse_q) && $past(ce)
    && $past(misc_q[gsd_pkg::GSD_MISC_EN]) |-> $past(pcnt_q) == PW'(DRDY_CYCLES - 1))
    else $error("data-ready pulse ended early");
  AST_DRDY_ROUTE: assert property (s_drdy_a
    |=> aux_line_a_oe && (aux_line_a_out == ($past(pulse_q) ~^ $past(misc_q[1]))))
    else $error("data-ready not driven on line a");
  AST_ST_START: assert property (s_st_go
    |=> (st_q == gsd_pkg::GSD_ST_RUN) && misc_q[gsd_pkg::GSD_MISC_IST] && (st_cnt_q == '0))
    else $error("self-test did not start");
  AST_ST_END: assert property ($fell(st_q == gsd_pkg::GSD_ST_RUN)
    |-> $past(st_cnt_q) == STW'(ST_CYCLES - 1) && !misc_q[gsd_pkg::GSD_MISC_IST])
    else $error("self-test ended at wrong count");
  AST_ST_FLAG: assert property (s_st_fail_end |=> flags_q[gsd_pkg::GSD_FLG_ST])
    else $error("self-test failure not flagged");
  AST_EXT_STIM: assert property (ce |=> {st_neg, st_pos} == $past(misc_q[9:8]))
    else $error("external stimulus does not follow enable bits");
  AST_LIVE_FLAGS: assert property (ce |=> flags_q[1:0] == $past({cond.supply_hi,
    cond.supply_lo}) && flags_q[4] == $past(cond.overrange))
    else $error("self-clearing flags wrong");
  AST_RD_CLEAR: assert property (rd_flags && (flag_set == 16'h0000)
    |=> (flags_q[9:5] == 5'h00) && (flags_q[3:2] == 2'h0) && (reg_rdata == $past(flags_q)))
    else $error("flag read did not return then clear");
  AST_PIN_IN: assert property (ce && reg_rd && (reg_addr == gsd_pkg::GSD_ADDR_PIN)
    && !pin_q[0] |=> reg_rdata[0] == $past(pin_sync[0]))
    else $error("input level not returned");
  AST_UNUSED: assert property (((pin_q & ~gsd_pkg::GSD_MASK_PIN) == 16'h0000)
    && ((flags_q & ~gsd_pkg::GSD_MASK_FLAGS) == 16'h0000))
    else $error("unused bits set");
endmodule
`default_nettype wire

// [logic/gsd_pkg.sv]
// package: register map, field positions, reset values and timing for the status/diag/pin block
`default_nettype none
package gsd_pkg;
  // -------------------------------------------------------------
  // register byte addresses (16-bit registers, even address)
  // -------------------------------------------------------------
  localparam logic [7:0]  GSD_ADDR_PIN   = 8'h32;  // pin_io_config
  localparam logic [7:0]  GSD_ADDR_MISC  = 8'h34;  // misc_config_selftest
  localparam logic [7:0]  GSD_ADDR_FLAGS = 8'h3c;  // error_flags

  localparam logic [15:0] GSD_RST_PIN    = 16'h0000;
  localparam logic [15:0] GSD_RST_MISC   = 16'h0000;
  localparam logic [15:0] GSD_RST_FLAGS  = 16'h0000;

  // implemented bits; everything else reads zero and ignores writes
  localparam logic [15:0] GSD_MASK_PIN   = 16'h0303;
  localparam logic [15:0] GSD_MASK_MISC  = 16'h0707;
  localparam logic [15:0] GSD_MASK_FLAGS = 16'h033f;

  // -------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------
  localparam int GSD_PIN_DIR_A  = 0;
  localparam int GSD_PIN_LVL_A  = 8;
  localparam int GSD_MISC_SEL   = 0;   // 1 = line b, 0 = line a
  localparam int GSD_MISC_POL   = 1;   // 1 = active high
  localparam int GSD_MISC_EN    = 2;
  localparam int GSD_MISC_XPOS  = 8;
  localparam int GSD_MISC_XNEG  = 9;
  localparam int GSD_MISC_IST   = 10;
  localparam int GSD_FLG_SUPLO  = 0;
  localparam int GSD_FLG_SUPHI  = 1;
  localparam int GSD_FLG_UPD    = 2;
  localparam int GSD_FLG_COMM   = 3;
  localparam int GSD_FLG_OVR    = 4;
  localparam int GSD_FLG_ST     = 5;
  localparam int GSD_FLG_ALM1   = 8;
  localparam int GSD_FLG_ALM2   = 9;

  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam int unsigned GSD_CLK_MHZ       = 200;
  localparam int unsigned GSD_ST_TIME_MS    = 35;
  localparam int unsigned GSD_ST_CYCLES     = GSD_ST_TIME_MS * 1000 * GSD_CLK_MHZ;
  // a quarter of the shortest sample period, centre of the allowed duty window
  localparam int unsigned GSD_DRDY_PULSE_US = 977;
  localparam int unsigned GSD_DRDY_CYCLES   = GSD_DRDY_PULSE_US * GSD_CLK_MHZ;

  // conditions from the sensor core, all on core_clk
  typedef struct packed {
    logic alarm2;
    logic alarm1;
    logic st_fail;
    logic overrange;
    logic comm_fail;
    logic upd_fail;
    logic supply_hi;
    logic supply_lo;
  } gsd_cond_t;

  // alarm engine claim on the two lines
  typedef struct packed {
    logic [1:0] en;
    logic [1:0] lvl;
  } gsd_alarm_pin_t;

  typedef enum logic [0:0] {GSD_ST_IDLE, GSD_ST_RUN} gsd_st_state_t;
endpackage
`default_nettype wire

// [logic/gsd_sync.sv]
// two-flop synchroniser for pin inputs
`default_nettype none
module gsd_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  // ------------------------------------------------------------
  // next values
  // ------------------------------------------------------------
  always_comb begin
    meta_d = ce ? d : meta_q;
    q_d    = ce ? meta_q : q;
  end

  // meta_q is read only by the second stage
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= meta_d;
      q      <= q_d;
    end
  end
endmodule
`default_nettype wire

// [verification/gsd_pin_peer.sv]
// pin-side peer: external driver and pull-ups on the two auxiliary lines
`default_nettype none
module gsd_pin_peer (
  input  wire logic       a_oe,
  input  wire logic       a_out,
  input  wire logic       b_oe,
  input  wire logic       b_out,
  input  wire logic [1:0] ext_en,
  input  wire logic [1:0] ext_lvl,
  output logic            line_a,
  output logic            line_b
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------
  // wire resolution
  // ----------------------------------------------------------
  // the device wins a clash; a line nobody drives floats to the pull-up level
  assign line_a = a_oe ? a_out : (ext_en[0] ? ext_lvl[0] : 1'b1);
  assign line_b = b_oe ? b_out : (ext_en[1] ? ext_lvl[1] : 1'b1);
endmodule
`default_nettype wire

// [verification/gsd_top_tb.sv]
// self-checking bench for the pin, data-ready, self-test and flag register bank
`default_nettype none
module gsd_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk, nrst, ce, reg_wr, reg_rd, sample_update;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  gsd_pkg::gsd_cond_t      cond;
  gsd_pkg::gsd_alarm_pin_t alarm_pin;
  logic        a_in, a_out, a_oe, b_in, b_out, b_oe, st_pos, st_neg, st_run;
  logic [1:0]  ext_en, ext_lvl;
  int          error_cnt, cmp_count, cyc_cnt, hits;

  gsd_top #(.ST_CYCLES(20), .DRDY_CYCLES(4)) DUT (
    .core_clk(core_clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sample_update(sample_update), .cond(cond),
    .alarm_pin(alarm_pin), .aux_line_a_in(a_in), .aux_line_a_out(a_out),
    .aux_line_a_oe(a_oe), .aux_line_b_in(b_in), .aux_line_b_out(b_out),
    .aux_line_b_oe(b_oe), .st_pos(st_pos), .st_neg(st_neg),
    .selftest_run(st_run));

  gsd_pin_peer PEER (
    .a_oe(a_oe), .a_out(a_out), .b_oe(b_oe), .b_out(b_out),
    .ext_en(ext_en), .ext_lvl(ext_lvl), .line_a(a_in), .line_b(b_in));

  // ----------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // the whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 3000) begin
      error_cnt++;
      results();
    end
  end

  // ----------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic chk16(input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic chk1(input logic exp, input logic got);
    chk16({15'h0000, exp}, {15'h0000, got});
  endtask
  // read data is registered at the strobe edge, sampled just after it
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk16(exp, reg_rdata);
  endtask
  task automatic done(input string name);
    $display("test %s done", name);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one update pulse, then count cycles the line shows its active level
  task automatic drdy(input logic line_b, input logic act);
    @(posedge core_clk);
    sample_update <= 1'b1;
    @(posedge core_clk);
    sample_update <= 1'b0;
    hits = 0;
    repeat (20) begin
      cyc(1);
      if ((line_b ? b_out : a_out) === act) hits++;
    end
    chk16(16'h0004, hits[15:0]);
  endtask

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    nrst          = 1'b0;
    ce            = 1'b1;
    reg_wr        = 1'b0;
    reg_rd        = 1'b0;
    sample_update = 1'b0;
    reg_addr      = 8'h00;
    reg_wdata     = 16'h0000;
    cond          = 8'h00;
    alarm_pin     = 4'h0;
    ext_en        = 2'b00;
    ext_lvl       = 2'b00;
    cyc_cnt       = 0;
    error_cnt     = 0;
    cmp_count     = 0;
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    // reset values, masks, unmapped and read-only places
    rd(gsd_pkg::GSD_ADDR_MISC, 16'h0000);
    wr(gsd_pkg::GSD_ADDR_MISC, 16'hfbff);
    rd(gsd_pkg::GSD_ADDR_MISC, 16'h0307);
    wr(gsd_pkg::GSD_ADDR_MISC, 16'h0000);
    wr(gsd_pkg::GSD_ADDR_FLAGS, 16'hffff);
    rd(gsd_pkg::GSD_ADDR_FLAGS, 16'h0000);
    rd(8'h40, 16'h0000);
    // a strobe while the clock enable is low must be dropped
    ce <= 1'b0;
    wr(gsd_pkg::GSD_ADDR_PIN, 16'h0303);
    ce <= 1'b1;
    rd(gsd_pkg::GSD_ADDR_PIN, 16'h0003);
    done("regs");
    // pins as outputs, then as inputs driven by the peer
    wr(gsd_pkg::GSD_ADDR_PIN, 16'hfe03 | 16'h0200);
    cyc(2);
    chk1(1'b1, a_oe);
    chk1(1'b0, a_out);
    chk1(1'b1, b_oe);
    chk1(1'b1, b_out);
    rd(gsd_pkg::GSD_ADDR_PIN, 16'h0203);
    ext_en <= 2'b11;
    ext_lvl <= 2'b01;
    wr(gsd_pkg::GSD_ADDR_PIN, 16'h0000);
    cyc(4);
    chk1(1'b0, a_oe);
    rd(gsd_pkg::GSD_ADDR_PIN, 16'h0001);
    ext_lvl <= 2'b10;
    cyc(4);
    rd(gsd_pkg::GSD_ADDR_PIN, 16'h0002);
    ext_en <= 2'b00;
    done("pins");
    // claims on line a: pin config loses to alarm, alarm to data-ready
    wr(gsd_pkg::GSD_ADDR_PIN, 16'h0101);
    cyc(2);
    chk1(1'b1, a_out);
    alarm_pin <= 4'b0100;
    cyc(3);
    chk1(1'b0, a_out);
    alarm_pin <= 4'b0101;
    wr(gsd_pkg::GSD_ADDR_MISC, 16'h0006);
    cyc(3);
    chk1(1'b0, a_out);
    // alarm claims line b low while data-ready sits on line a
    alarm_pin <= 4'b1001;
    cyc(3);
    chk1(1'b1, b_oe);
    chk1(1'b0, b_out);
    alarm_pin <= 4'b0000;
    done("priority");
    // data-ready on line a active high, then line b active low
    drdy(1'b0, 1'b1);
    wr(gsd_pkg::GSD_ADDR_MISC, 16'h0005);
    cyc(3);
    chk1(1'b1, b_oe);
    chk1(1'b1, b_out);
    drdy(1'b1, 1'b0);
    wr(gsd_pkg::GSD_ADDR_MISC, 16'h0000);
    wr(gsd_pkg::GSD_ADDR_PIN, 16'h0000);
    done("drdy");
    // external stimulus held, internal test started and awaited by the host
    wr(gsd_pkg::GSD_ADDR_MISC, 16'h0300);
    cyc(10);
    chk1(1'b1, st_pos);
    chk1(1'b1, st_neg);
    wr(gsd_pkg::GSD_ADDR_MISC, 16'h0100);
    cyc(2);
    chk1(1'b0, st_neg);
    cond <= 8'h20;
    wr(gsd_pkg::GSD_ADDR_MISC, 16'h0400);
    cyc(2);
    chk1(1'b1, st_run);
    rd(gsd_pkg::GSD_ADDR_MISC, 16'h0400);
    // clearing bit 10 mid-run must not cut the test short
    wr(gsd_pkg::GSD_ADDR_MISC, 16'h0000);
    rd(gsd_pkg::GSD_ADDR_MISC, 16'h0400);
    cyc(30); // host waits out the test time
    chk1(1'b0, st_run);
    rd(gsd_pkg::GSD_ADDR_MISC, 16'h0000);
    rd(gsd_pkg::GSD_ADDR_FLAGS, 16'h0020);
    rd(gsd_pkg::GSD_ADDR_FLAGS, 16'h0000);
    cond <= 8'h00;
    done("selftest");
    // sticky flags against self-clearing ones
    @(posedge core_clk);
    cond <= 8'hdf;
    @(posedge core_clk);
    cond <= 8'h00;
    cyc(2);
    rd(gsd_pkg::GSD_ADDR_FLAGS, 16'h030c);
    rd(gsd_pkg::GSD_ADDR_FLAGS, 16'h0000);
    cond <= 8'h12;
    cyc(2);
    rd(gsd_pkg::GSD_ADDR_FLAGS, 16'h0012);
    rd(gsd_pkg::GSD_ADDR_FLAGS, 16'h0012);
    cond <= 8'h01;
    cyc(2);
    rd(gsd_pkg::GSD_ADDR_FLAGS, 16'h0001);
    cond <= 8'h00;
    cyc(2);
    rd(gsd_pkg::GSD_ADDR_FLAGS, 16'h0000);
    done("flags");
    results();
  end
endmodule
`default_nettype wire
